// ---- core/pibc_ctrl.sv ----
// Purpose : control and status of the second packet insertion buffer
// Assumes : host register port on clk, stream and timer strobes on clk
// Notes   : packet ram is 64 words, not reset; fifo decouples the output
//
// Function
// RULE_01: write-pointer clear bit zeroes pointer when disabled
// RULE_02: write pointer shows next word, advances per write
// RULE_03: read-pointer clear bit zeroes pointer when disabled
// RULE_04: read pointer shows next word a read returns
// RULE_05: while armed, read pointer follows hardware fetch
// RULE_06: packet words carry selected target buffer
// RULE_07: fill bit loads ones from write pointer onward
// RULE_08: arm bit starts packet insertion
// RULE_09: hardware clears arm bit after successful insertion
// RULE_10: arming zeroes both read and write pointers
// RULE_11: software configures everything before arming
// RULE_12: software writes packet length in quadlets
// RULE_13: insert once gap reaches programmed threshold
// RULE_14: threshold uses cycle count and cycle offset
// RULE_15: reserved bits ignore writes and read zero
// RULE_16: port writes store at write pointer, ignored armed
// RULE_17: packet ram holds no reset value
// RULE_18: gap timer restarts on each stream byte

`timescale 1ns/1ps

module pibc_ctrl #(
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // host register port
    input  wire logic [9:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [31:0] regWdata,
    output logic [31:0]      regRdata,
    output logic             regRvalid,
    // timing strobes
    input  wire logic        cycleTick,
    input  wire logic        streamByteStrobe,
    // insertion stream to the data buffers
    output logic             insValid,
    input  wire logic        insReady,
    output logic [31:0]      insData,
    output logic [2:0]       insTarget,
    output logic             insLast,
    // status
    output logic             insertionArmed
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam int DEPTH = 1 << pibc_pkg::PTR_W;
    localparam int WW    = $bits(pibc_pkg::pibc_word_t);

    if (FIFO_DEPTH < 2)
    begin : g_bad
        $error("pibc_ctrl: FIFO_DEPTH must be at least 2");
    end

    logic [31:0]               mem [DEPTH];         // [RULE_17]
    pibc_pkg::pibc_state_t     state_q;
    pibc_pkg::pibc_state_t     state_d;
    logic [5:0]                wr_pointer_q;
    logic [5:0]                wr_pointer_d;
    logic [5:0]                rd_pointer_q;
    logic [5:0]                rd_pointer_d;
    logic [5:0]                fillAddr_q;
    logic [5:0]                fillAddr_d;
    logic                      armed_q;
    logic                      armed_d;
    logic [2:0]                target_q;
    logic [2:0]                target_d;
    logic [5:0]                len_q;
    logic [5:0]                len_d;
    logic [15:0]               thr_q;
    logic [15:0]               thr_d;
    logic [31:0]               rdata_q;
    logic [31:0]               rdata_d;
    logic                      rvalid_q;
    logic                      memWe;
    logic [5:0]                memAddr;
    logic [31:0]               memWdata;
    logic                      portWr;
    logic                      portRd;
    logic                      csr0Wr;
    logic                      csr1Wr;
    logic                      gapReached;
    logic                      push;
    logic                      pushReady;
    logic                      fifoEmpty;
    pibc_pkg::pibc_word_t      pushWord;
    pibc_pkg::pibc_word_t      outWord;
    logic [31:0]               csr0Image;
    logic [31:0]               csr1Image;

    // ------------------------------------------------------------------
    // address decode and register images
    // ------------------------------------------------------------------
    // unused and reserved positions stay zero
    always_comb
    begin
        portWr = regWrite && pibc_pkg::pibc_hit(regAddr,
                                                pibc_pkg::OFS_RAM_PORT);
        portRd = regRead && pibc_pkg::pibc_hit(regAddr,
                                               pibc_pkg::OFS_RAM_PORT);
        csr0Wr = regWrite && pibc_pkg::pibc_hit(regAddr,
                                                pibc_pkg::OFS_CSR0);
        csr1Wr = regWrite && pibc_pkg::pibc_hit(regAddr,
                                                pibc_pkg::OFS_CSR1);
        csr0Image = pibc_pkg::ZERO_WORD;                      // [RULE_15]
        csr0Image[pibc_pkg::WR_PTR_LSB +: pibc_pkg::PTR_W] = wr_pointer_q;
        csr0Image[pibc_pkg::RD_PTR_LSB +: pibc_pkg::PTR_W] = rd_pointer_q;
        csr0Image[pibc_pkg::TARGET_LSB +: pibc_pkg::TARGET_W] = target_q;
        csr0Image[pibc_pkg::ARM_BIT] = armed_q;
        csr0Image[pibc_pkg::LEN_LSB +: pibc_pkg::LEN_W] = len_q;
        csr1Image = pibc_pkg::ZERO_WORD;                      // [RULE_15]
        csr1Image[pibc_pkg::THR_W-1:0] = thr_q;
    end

    // ------------------------------------------------------------------
    // main sequencer: host loading, fill, wait for gap, fetch, drain
    // ------------------------------------------------------------------
    // pointers are shared by host and fetcher; the state decides who owns
    // them, so no host access can move the pointers of an armed packet
    always_comb
    begin
        state_d    = state_q;
        wr_pointer_d    = wr_pointer_q;
        rd_pointer_d    = rd_pointer_q;
        fillAddr_d = fillAddr_q;
        armed_d    = armed_q;
        target_d   = target_q;
        len_d      = len_q;
        thr_d      = thr_q;
        memWe      = 1'b0;
        memAddr    = wr_pointer_q;
        memWdata   = regWdata;
        push       = 1'b0;
        pushWord.data   = mem[rd_pointer_q];
        pushWord.target = target_q;                            // [RULE_06]
        pushWord.last   = (rd_pointer_q == len_q - 6'd1);
        rdata_d    = rdata_q;

        // configuration fields stay writable at all times
        if (csr0Wr)
        begin
            target_d = regWdata[pibc_pkg::TARGET_LSB +: pibc_pkg::TARGET_W];
            len_d    = regWdata[pibc_pkg::LEN_LSB +: pibc_pkg::LEN_W];
        end
        if (csr1Wr)
        begin
            thr_d = regWdata[pibc_pkg::THR_W-1:0];            // [RULE_14]
        end

        // read data mux; the ram port answers zero while armed
        if (regRead)
        begin
            if (portRd)
            begin
                rdata_d = armed_q ? pibc_pkg::ZERO_WORD : mem[rd_pointer_q];
            end
            else if (pibc_pkg::pibc_hit(regAddr, pibc_pkg::OFS_CSR0))
            begin
                rdata_d = csr0Image;
            end
            else if (pibc_pkg::pibc_hit(regAddr, pibc_pkg::OFS_CSR1))
            begin
                rdata_d = csr1Image;
            end
            else
            begin
                rdata_d = pibc_pkg::ZERO_WORD;
            end
        end

        case (state_q)
            pibc_pkg::PIBC_IDLE:
            begin
                if (portWr)
                begin
                    memWe   = 1'b1;                            // [RULE_16]
                    wr_pointer_d = wr_pointer_q + 6'd1;                  // [RULE_02]
                end
                if (portRd)
                begin
                    rd_pointer_d = rd_pointer_q + 6'd1;                  // [RULE_04]
                end
                if (csr0Wr)
                begin
                    if (regWdata[pibc_pkg::WR_CLR_BIT])
                    begin
                        wr_pointer_d = '0;                          // [RULE_01]
                    end
                    if (regWdata[pibc_pkg::RD_CLR_BIT])
                    begin
                        rd_pointer_d = '0;                          // [RULE_03]
                    end
                    if (regWdata[pibc_pkg::FILL_BIT])
                    begin
                        fillAddr_d = wr_pointer_q;                  // [RULE_07]
                        state_d    = pibc_pkg::PIBC_FILL;
                    end
                    else if (regWdata[pibc_pkg::ARM_BIT])
                    begin
                        armed_d = 1'b1;                        // [RULE_08]
                        wr_pointer_d = '0;                          // [RULE_10]
                        rd_pointer_d = '0;
                        state_d = pibc_pkg::PIBC_WAIT;
                    end
                end
            end
            pibc_pkg::PIBC_FILL:
            begin
                // host port writes are dropped while the fill owns the ram
                memWe    = 1'b1;
                memAddr  = fillAddr_q;
                memWdata = pibc_pkg::FILL_WORD;                // [RULE_07]
                fillAddr_d = fillAddr_q + 6'd1;
                if (fillAddr_q == pibc_pkg::PTR_LAST)
                begin
                    state_d = pibc_pkg::PIBC_IDLE;
                end
            end
            pibc_pkg::PIBC_WAIT:
            begin
                if (csr0Wr && !regWdata[pibc_pkg::ARM_BIT])
                begin
                    armed_d = 1'b0;
                    state_d = pibc_pkg::PIBC_IDLE;
                end
                else if (gapReached)
                begin
                    if (len_q == '0)
                    begin
                        armed_d = 1'b0;                        // [RULE_09]
                        state_d = pibc_pkg::PIBC_IDLE;
                    end
                    else
                    begin
                        state_d = pibc_pkg::PIBC_SEND;         // [RULE_13]
                    end
                end
            end
            pibc_pkg::PIBC_SEND:
            begin
                // fifo back-pressure stalls the fetch here
                if (pushReady)
                begin
                    push    = 1'b1;
                    rd_pointer_d = rd_pointer_q + 6'd1;                  // [RULE_05]
                    if (pushWord.last)
                    begin
                        state_d = pibc_pkg::PIBC_DRAIN;
                    end
                end
            end
            pibc_pkg::PIBC_DRAIN:
            begin
                // success only once the last word has left the fifo
                if (fifoEmpty)
                begin
                    armed_d = 1'b0;                            // [RULE_09]
                    state_d = pibc_pkg::PIBC_IDLE;
                end
            end
            default:
            begin
                state_d = pibc_pkg::PIBC_IDLE;
                armed_d = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q    <= pibc_pkg::PIBC_IDLE;
            wr_pointer_q    <= '0;
            rd_pointer_q    <= '0;
            fillAddr_q <= '0;
            armed_q    <= 1'b0;
            target_q   <= '0;
            len_q      <= '0;
            thr_q      <= '0;
            rdata_q    <= '0;
            rvalid_q   <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            wr_pointer_q    <= wr_pointer_d;
            rd_pointer_q    <= rd_pointer_d;
            fillAddr_q <= fillAddr_d;
            armed_q    <= armed_d;
            target_q   <= target_d;
            len_q      <= len_d;
            thr_q      <= thr_d;
            rdata_q    <= rdata_d;
            rvalid_q   <= regRead;
        end
    end

    // packet ram write port, no reset on purpose
    always_ff @(posedge clk)
    begin
        if (memWe)
        begin
            mem[memAddr] <= memWdata;                          // [RULE_16]
        end
    end

    // ------------------------------------------------------------------
    // gap measurement and output buffer
    // ------------------------------------------------------------------
    pibc_gap_timer u_gap (
        .clk        (clk),
        .srst       (srst),
        .cycleTick  (cycleTick),
        .streamByte (streamByteStrobe),
        .threshold  (thr_q),
        .gapReached (gapReached)
    );

    pibc_fifo #(
        .WIDTH (WW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .srst     (srst),
        .inValid  (push),
        .inReady  (pushReady),
        .inData   (pushWord),
        .outValid (insValid),
        .outReady (insReady),
        .outData  (outWord),
        .empty    (fifoEmpty)
    );

    // output mapping
    assign insData        = outWord.data;
    assign insTarget      = outWord.target;
    assign insLast        = outWord.last;
    assign regRdata       = rdata_q;
    assign regRvalid      = rvalid_q;
    assign insertionArmed = armed_q;

endmodule

// ---- core/pibc_pkg.sv ----
// Purpose : shared constants and types of the packet insertion buffer control
// Assumes : byte addressed register port, 32-bit data words
// Notes   : every field position and offset lives here; reset values sit in pibc_ctrl

package pibc_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam int             ADDR_W        = 10;
    localparam logic [9:0]     OFS_RAM_PORT  = 10'h0e4;
    localparam logic [9:0]     OFS_CSR0      = 10'h0e8;
    localparam logic [9:0]     OFS_CSR1      = 10'h0ec;

    // ------------------------------------------------------------------
    // field layout of insertion_b_config_status
    // ------------------------------------------------------------------
    localparam int             WR_CLR_BIT    = 30;
    localparam int             WR_PTR_LSB    = 24;
    localparam int             RD_CLR_BIT    = 22;
    localparam int             RD_PTR_LSB    = 16;
    localparam int             TARGET_LSB    = 8;
    localparam int             FILL_BIT      = 7;
    localparam int             ARM_BIT       = 6;
    localparam int             LEN_LSB       = 0;
    localparam int             PTR_W         = 6;
    localparam int             TARGET_W      = 3;
    localparam int             LEN_W         = 6;
    localparam int             THR_W         = 16;

    // ------------------------------------------------------------------
    // values and cycle-timer format
    // ------------------------------------------------------------------
    localparam logic [31:0]    FILL_WORD     = 32'hFFFF_FFFF;
    localparam logic [31:0]    ZERO_WORD     = 32'h0000_0000;
    localparam logic [5:0]     PTR_LAST      = 6'h3f;
    localparam int             CYC_OFF_W     = 12;
    localparam int             CYC_CNT_W     = 4;
    localparam logic [11:0]    CYC_OFF_MAX   = 12'hbff;
    localparam logic [3:0]     CYC_CNT_MAX   = 4'hf;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0]           data;
        logic [TARGET_W-1:0]   target;
        logic                  last;
    } pibc_word_t;

    typedef enum logic [2:0] {
        PIBC_IDLE  = 3'b000,
        PIBC_WAIT  = 3'b001,
        PIBC_SEND  = 3'b011,
        PIBC_DRAIN = 3'b010,
        PIBC_FILL  = 3'b100
    } pibc_state_t;

    // address match, used by write and read decode alike
    function automatic logic pibc_hit(input logic [9:0] addr,
                                      input logic [9:0] ofs);
        pibc_hit = (addr == ofs);
    endfunction

endpackage

// ---- core/pibc_fifo.sv ----
// Purpose : small synchronous fifo between word fetch and stream output
// Assumes : single clock, srst synchronous active high
// Notes   : depth must be a power of two; output data comes from flops

`timescale 1ns/1ps

module pibc_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  empty
);
    localparam int AW = $clog2(DEPTH);

    // refuse shapes the pointer arithmetic cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad
        $error("pibc_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      wp_d;
    logic [AW:0]      rp_q;
    logic [AW:0]      rp_d;
    logic             push;
    logic             pop;

    // one extra pointer bit tells full from empty
    always_comb
    begin
        empty    = (wp_q == rp_q);
        inReady  = !((wp_q[AW] != rp_q[AW]) &&
                     (wp_q[AW-1:0] == rp_q[AW-1:0]));
        outValid = !empty;
        push     = inValid && inReady;
        pop      = outValid && outReady;
        wp_d     = push ? wp_q + 1'b1 : wp_q;
        rp_d     = pop ? rp_q + 1'b1 : rp_q;
        outData  = mem_q[rp_q[AW-1:0]];
    end

    // storage is not reset; pointers are
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (push)
        begin
            mem_q[wp_q[AW-1:0]] <= inData;
        end
    end

endmodule

// ---- core/pibc_gap_timer.sv ----
// Purpose : measure the idle gap of the transport stream in timer units
// Assumes : cycleTick pulses once per cycle-timer offset step, same clock
// Notes   : count saturates so a long gap never wraps back below threshold

`timescale 1ns/1ps

module pibc_gap_timer (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // timing inputs
    input  wire logic        cycleTick,
    input  wire logic        streamByte,
    input  wire logic [15:0] threshold,
    // result
    output logic             gapReached
);
    logic [11:0] off_q;
    logic [11:0] off_d;
    logic [3:0]  cnt_q;
    logic [3:0]  cnt_d;
    logic        hit_q;
    logic        hit_d;

    // offset wraps into count, restart on each stream byte
    always_comb
    begin
        off_d = off_q;
        cnt_d = cnt_q;
        if (streamByte)
        begin
            off_d = '0;                              // [RULE_18]
            cnt_d = '0;
        end
        else if (cycleTick && !(cnt_q == pibc_pkg::CYC_CNT_MAX &&
                                off_q == pibc_pkg::CYC_OFF_MAX))
        begin
            if (off_q == pibc_pkg::CYC_OFF_MAX)
            begin
                off_d = '0;                          // [RULE_14]
                cnt_d = cnt_q + 1'b1;
            end
            else
            begin
                off_d = off_q + 1'b1;
            end
        end
        hit_d = ({cnt_d, off_d} >= threshold);       // [RULE_13]
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            off_q <= '0;
            cnt_q <= '0;
            hit_q <= 1'b0;
        end
        else
        begin
            off_q <= off_d;
            cnt_q <= cnt_d;
            hit_q <= hit_d;
        end
    end

    assign gapReached = hit_q;

endmodule

// ---- sim/pibc_ctrl_asserts.sv ----
// Purpose: port checks of pibc_ctrl
// Assumes: one clock, srst sync active high
// Notes: bound in the bench top file
`timescale 1ns/1ps
module pibc_ctrl_asserts #(
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // register port
    input wire logic [9:0]  regAddr,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regWdata,
    input wire logic [31:0] regRdata,
    input wire logic        regRvalid,
    // strobes and stream
    input wire logic        cycleTick,
    input wire logic        streamByteStrobe,
    input wire logic        insValid,
    input wire logic        insReady,
    input wire logic [31:0] insData,
    input wire logic [2:0]  insTarget,
    input wire logic        insLast,
    input wire logic        insertionArmed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic lastAcc;
    // final packet word taken by the buffer side
    assign lastAcc = insValid && insReady && insLast;
    // ----
    // assertions
    // ----
    read_answer_a: assert property (regRead |=> regRvalid)
        else $error("read not answered");
    no_stray_a: assert property (!regRead |=> !regRvalid)
        else $error("answer without read");
    csr0_rsvd_a: assert property (regRead && regAddr ==
        pibc_pkg::OFS_CSR0 |=> (regRdata & 32'hC080_F880) == 32'h0)
        else $error("reserved bits set");
    csr1_rsvd_a: assert property (regRead && regAddr ==
        pibc_pkg::OFS_CSR1 |=> regRdata[31:16] == 16'h0)
        else $error("upper half set");
    port_locked_a: assert property (regRead && insertionArmed &&
        regAddr == pibc_pkg::OFS_RAM_PORT |=> regRdata == 32'h0)
        else $error("port read while armed");
    arm_start_a: assert property (regWrite && regWdata[6] &&
        !regWdata[7] && !insertionArmed &&
        regAddr == pibc_pkg::OFS_CSR0 |=> insertionArmed)
        else $error("arm ignored");
    word_hold_a: assert property (insValid && !insReady |=>
        insValid && $stable({insData, insTarget, insLast}))
        else $error("word changed while stalled");
    auto_clear_a: assert property (lastAcc |-> ##[1:2] !insertionArmed)
        else $error("arm not cleared");
    clear_cause_a: assert property ($fell(insertionArmed) |->
        $past(regWrite) || $past(lastAcc) || $past(lastAcc, 2))
        else $error("arm cleared without cause");
    valid_armed_a: assert property (insValid |-> insertionArmed)
        else $error("word while idle");
    cover property ($rose(insertionArmed));
    cover property (lastAcc);
    cover property (insValid && !insReady);
endmodule

// ---- sim/pibc_sink_model.sv ----
// Purpose: data buffer side of the insertion stream
// Assumes: a word moves when insValid and insReady meet at posedge
// Notes: slow mode gives ready one cycle in four so the fifo fills
`timescale 1ns/1ps
module pibc_sink_model (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // insertion stream
    input wire logic        insValid,
    output logic            insReady,
    input wire logic [31:0] insData,
    input wire logic [2:0]  insTarget,
    input wire logic        insLast,
    // pacing
    input wire logic        slow
);
    logic [35:0] got[$];
    logic [1:0]  pace = 2'h0;
    initial insReady = 1'b0;
    // keep words, move ready only just after an edge
    always @(posedge clk)
    begin
        if (!srst && insValid && insReady)
            got.push_back({insData, insTarget, insLast});
        pace <= srst ? 2'h0 : pace + 2'h1;
        insReady <= !srst && (!slow || pace == 2'h3);
    end
endmodule

// ---- sim/pibc_ctrl_tb.sv ----
// Purpose: self-checking bench of pibc_ctrl
// Assumes: inputs move at the falling edge
// Notes: an array of ram words is the model of the buffer
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errorCnt++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module pibc_ctrl_tb;
    localparam logic [9:0] PORT = pibc_pkg::OFS_RAM_PORT;
    localparam logic [9:0] CSR0 = pibc_pkg::OFS_CSR0;
    localparam logic [9:0] CSR1 = pibc_pkg::OFS_CSR1;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [9:0]  regAddr = 10'h000;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata;
    logic        regRvalid;
    logic        cycleTick = 1'b1;
    logic        streamByteStrobe = 1'b0;
    logic        hold = 1'b0;
    logic        slow = 1'b0;
    logic        insValid;
    logic        insReady;
    logic [31:0] insData;
    logic [2:0]  insTarget;
    logic        insLast;
    logic        insertionArmed;
    logic [31:0] mem[64];
    logic [2:0]  tgt;
    int          errorCnt = 0;
    int          compares = 0;
    int          seed = 32'h8e59;
    int          i;
    int          r;
    int          cnt;
    always #50 clk = ~clk;
    // stream bytes every other cycle keep the gap short
    always @(negedge clk) streamByteStrobe <= hold & ~streamByteStrobe;
    // timer ticks every other cycle once bytes stop, so tick gating shows
    always @(negedge clk) cycleTick <= ~cycleTick | hold;
    pibc_ctrl DUT (.clk, .srst, .regAddr, .regWrite, .regRead, .regWdata,
        .regRdata, .regRvalid, .cycleTick, .streamByteStrobe, .insValid,
        .insReady, .insData, .insTarget, .insLast, .insertionArmed);
    pibc_sink_model SINK (.clk, .srst, .insValid, .insReady, .insData,
        .insTarget, .insLast, .slow);
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(negedge clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        `CHK(regRvalid, 1'b1)
        `CHK(regRdata, e)
    endtask
    task automatic finishTest();
        $display("compares %0d mismatches %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (4) @(negedge clk);
        srst = 1'b0;
        rd(CSR0, 32'h0);
        rd(10'h100, 32'h0);
        wr(CSR1, 32'hFFFF_FFFF);
        rd(CSR1, 32'h0000_FFFF);
        wr(CSR0, 32'hBFBF_FF3F);
        rd(CSR0, 32'h0000_073F);
        for (i = 0; i < 5; i++)
        begin
            mem[i] = $random(seed);
            wr(PORT, mem[i]);
        end
        wr(CSR0, 32'h0040_073F);
        rd(CSR0, 32'h0500_073F);
        for (i = 0; i < 5; i++)
            rd(PORT, mem[i]);
        rd(CSR0, 32'h0505_073F);
        wr(CSR0, 32'h4040_073F);
        rd(CSR0, 32'h0000_073F);
        wr(PORT, mem[0]);
        wr(PORT, mem[1]);
        wr(CSR0, 32'h0000_0780);
        repeat (70) @(negedge clk);
        wr(CSR0, 32'h0040_0700);
        rd(CSR0, 32'h0200_0700);
        for (i = 0; i < 64; i++)
            rd(PORT, i < 2 ? mem[i] : pibc_pkg::FILL_WORD);
        $display("test ram port done");
        for (r = 0; r < 2; r++)
        begin
            slow = r[0];
            tgt = 3'($random(seed));
            wr(CSR0, 32'h4000_0000);
            for (i = 0; i < 4; i++)
            begin
                mem[i] = $random(seed);
                wr(PORT, mem[i]);
            end
            wr(CSR1, r ? 32'h0000_1002 : 32'h0000_0003);
            hold = 1'b1;
            wr(CSR0, {21'h0, tgt, 2'b01, 6'h04});
            wr(PORT, 32'h1234_5678);
            rd(CSR0, {21'h0, tgt, 2'b01, 6'h04});
            rd(PORT, 32'h0);
            repeat (20) @(negedge clk);
            `CHK(SINK.got.size(), 0)
            hold = 1'b0;
            cnt = 0;
            while (insertionArmed !== 1'b0 && cnt < 9000)
            begin
                @(negedge clk);
                cnt++;
            end
            if (cnt == 9000)
            begin
                errorCnt++;
                finishTest();
            end
            `CHK(cnt >= (r ? 6147 : 5), 1'b1)
            `CHK(SINK.got.size(), 4)
            for (i = 0; i < 4; i++)
                `CHK(SINK.got[i], {mem[i], tgt, i == 3})
            rd(CSR0, {10'h0, 6'h04, 5'h0, tgt, 2'b00, 6'h04});
            SINK.got.delete();
            $display("test insertion round done");
        end
        finishTest();
    end
endmodule
bind pibc_ctrl pibc_ctrl_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) CHKR (.clk,
    .srst, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .regRvalid,
    .cycleTick, .streamByteStrobe, .insValid, .insReady, .insData,
    .insTarget, .insLast, .insertionArmed);
